// ---- logic/tsb_pkg.sv ----
// constants and types for the test stream header and payload builder
package tsb_pkg;
    localparam logic [15:0] UDP_HDR_LEN = 16'h0008;
    localparam logic [15:0] TCP_HDR_LEN = 16'h0014;
    localparam logic [3:0] TCP_HDR_WORDS = 4'h5;
    localparam logic [3:0] TCP_RSVD = 4'h0;
    localparam logic [7:0] MCAST_PREFIX = 8'hFF;
    localparam logic [3:0] TAG_MIN = 4'h4;
    localparam logic [3:0] TAG_MAX = 4'hD;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 9;
    localparam logic [7:0] FLG_FIN = 8'h01;
    localparam logic [7:0] FLG_SYN = 8'h02;
    localparam logic [7:0] FLG_PSH = 8'h08;
    localparam logic [7:0] FLG_ACK = 8'h10;
    localparam logic [7:0] FLG_URG = 8'h20;
    localparam logic [7:0] FLG_ECE = 8'h40;
    localparam logic [7:0] FLG_CWR = 8'h80;
    localparam logic [7:0] ENGINE_KEEP = 8'hE0;
    localparam logic [7:0] PAT_ALT_BYTE = 8'h55;
    localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;
    localparam logic [31:0] VAR_RND_SEED = 32'h00000001;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    typedef enum logic [2:0] {
        PAT_5555, PAT_USER, PAT_PRBS9, PAT_PRBS11,
        PAT_PRBS15, PAT_PRBS20, PAT_PRBS23, PAT_PRBS31
    } tsb_pat_t;
    typedef enum logic [1:0] {CHG_INC, CHG_DEC, CHG_RND} tsb_chg_t;
    typedef enum {S_IDLE, S_PAY, S_HDR} tsb_state_t;
    typedef enum {CN_CLOSED, CN_SYNSENT, CN_LISTEN, CN_SYNRCVD, CN_OPEN} tsb_conn_t;
endpackage

// ---- logic/tsb_builder.sv ----
// payload fifo and upper-layer header and payload builder for test frames
// Functional notes
// - off-net destinations go to default gateway
// - group address needs all-ones leading byte
// - joined: accept source equal group address
// - UDP length is header plus data
// - null option sends zero UDP checksum
// - SYN uses seq, next segment seq plus one
// - auto increment counts data bytes from zero
// - ACK field carries next expected sequence
// - data offset is header size in words
// - reserved TCP bits sent as zero
// - flags programmable, engine owns most when connecting
// - auto connect handshakes before any traffic
// - listen waits peer, captures its addresses
// - urgent pointer sent when URG set
// - TCP checksum covers header and data
// - user mode repeats 32-bit user word
// - no continuation restarts pattern each frame
// - continuation carries pattern across frames
// - payload opens with 4-13 byte tag
// - two variable fields by bit offset, length
// - fields increment, decrement or random in range
`timescale 1ns/1ps
module tsb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_reg;
    logic [AW:0] rdPtr_reg;
    logic full;

    // full when pointers differ only in the wrap bit
    assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
    assign inReady = !full;
    assign outValid = wrPtr_reg != rdPtr_reg;
    assign outData = mem[rdPtr_reg[AW-1:0]];

    // storage write
    always_ff @(posedge clk) begin
        if (inValid && inReady) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    // pointers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (inValid && inReady) wrPtr_reg <= wrPtr_reg + 1'b1;
            if (outValid && outReady) rdPtr_reg <= rdPtr_reg + 1'b1;
        end
    end
endmodule // tsb_fifo

module tsb_builder (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic gatewayEn,
    input wire logic [31:0] gatewayIp,
    input wire logic [31:0] prefixMask,
    input wire logic [31:0] srcIp,
    input wire logic [31:0] dstIp,
    output logic [31:0] nextHopIp,
    input wire logic [127:0] groupAddr,
    output logic groupOk,
    input wire logic joined,
    input wire logic rxValid,
    input wire logic [127:0] rxSrcAddr,
    input wire logic [31:0] rxDstIp,
    output logic rxAccept,
    input wire logic useTcp,
    input wire logic udpNullCsum,
    input wire logic [15:0] srcPort,
    input wire logic [15:0] dstPort,
    input wire logic [15:0] window,
    input wire logic [31:0] cfgSeq,
    input wire logic seqAutoInc,
    input wire logic [31:0] cfgAck,
    input wire logic [7:0] cfgFlags,
    input wire logic [15:0] urgPtr,
    input wire logic autoConnect,
    input wire logic listenMode,
    input wire logic rxSyn,
    input wire logic rxSynAck,
    input wire logic rxAck,
    input wire logic [31:0] rxSeq,
    input wire logic [47:0] rxPeerMac,
    input wire logic [31:0] rxPeerIp,
    input wire logic [15:0] rxPeerPort,
    output logic [47:0] peerMac,
    output logic [31:0] peerIp,
    output logic [15:0] peerPort,
    output logic connOpen,
    output logic txAllowed,
    input wire logic [15:0] pseudoSum,
    input wire logic txGo,
    input wire logic [15:0] payloadLen,
    input wire tsb_pkg::tsb_pat_t patSel,
    input wire logic [31:0] userPattern,
    input wire logic crossFrame,
    input wire logic [3:0] tagLen,
    input wire logic [103:0] measTag,
    input wire logic [1:0][18:0] varOffset,
    input wire logic [1:0][5:0] varLen,
    input wire logic [1:0][31:0] varStart,
    input wire logic [1:0][31:0] varEnd,
    input wire logic [1:0][31:0] varStep,
    input wire logic [1:0][1:0] varType,
    output logic [1:0][31:0] varValue,
    output logic busy,
    output logic hdrValid,
    output logic hdrIsCtl,
    output logic [31:0] seqField,
    output logic [31:0] ackField,
    output logic [7:0] offResField,
    output logic [7:0] flagsField,
    output logic [15:0] urgField,
    output logic [15:0] dstPortField,
    output logic [15:0] lenField,
    output logic [15:0] csumField,
    output logic payValid,
    output logic [7:0] payData,
    output logic payLast,
    input wire logic payReady
);
    import tsb_pkg::*;

    tsb_state_t state_reg;
    tsb_conn_t conn_reg;
    logic needConn, takePend, push, last, isTag, isCtl_reg, synSent_reg, fifoReady;
    logic [7:0] pendFlags_reg, setPend, ctlFlags_reg, segFlags, rawByte, outByte;
    logic [15:0] frameLen_reg, byteIdx_reg, dport, segLen, csumCalc;
    logic [31:0] sum_reg, ackExp_reg, dataSent_reg, seqVal, ackVal, hsum;
    logic [16:0] fold1;
    logic [15:0] fold2;
    logic [3:0] tagLenC;
    logic [30:0] prbs_reg;
    logic [38:0] prbsNext;
    logic [1:0] uPos_reg;
    logic [1:0][31:0] curVal;
    logic [18:0] pos, rel;
    logic [4:0] vIdx;

    // eight pattern bits per byte from a selectable lfsr
    function automatic logic [38:0] prbs8(input logic [30:0] s, input tsb_pat_t p);
        logic [30:0] t;
        logic [7:0] b;
        logic [4:0] ln;
        logic [4:0] tp;
        logic fb;
        t = s;
        b = 8'h00;
        case (p)
            PAT_PRBS9: begin ln = 5'd9; tp = 5'd5; end // period 511 bits
            PAT_PRBS11: begin ln = 5'd11; tp = 5'd9; end
            PAT_PRBS15: begin ln = 5'd15; tp = 5'd14; end
            PAT_PRBS20: begin ln = 5'd20; tp = 5'd3; end
            PAT_PRBS23: begin ln = 5'd23; tp = 5'd18; end
            default: begin ln = 5'd31; tp = 5'd28; end
        endcase
        for (int i = 0; i < 8; i++) begin
            fb = t[ln - 5'd1] ^ t[tp - 5'd1];
            t = {t[29:0], fb};
            b = {b[6:0], fb};
        end
        return {t, b};
    endfunction

    // address handling: next hop, group check, receive filter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {nextHopIp, groupOk, rxAccept} <= '0;
        end else begin
            if (gatewayEn && (((dstIp ^ srcIp) & prefixMask) != RST_WORD)) begin
                nextHopIp <= gatewayIp;
            end else begin
                nextHopIp <= dstIp;
            end
            groupOk <= groupAddr[127:120] == MCAST_PREFIX;
            if (joined && groupOk) begin
                rxAccept <= rxValid && (rxSrcAddr == groupAddr);
            end else begin
                rxAccept <= rxValid && (rxDstIp == srcIp);
            end
        end
    end

    assign needConn = useTcp && (autoConnect || listenMode);
    assign connOpen = conn_reg == CN_OPEN;
    assign txAllowed = !needConn || connOpen;
    assign busy = state_reg != S_IDLE;
    assign takePend = (state_reg == S_IDLE) && (pendFlags_reg != 8'h00);

    // handshake requests raised by the connection engine
    always_comb begin
        setPend = 8'h00;
        if (needConn) begin
            unique case (conn_reg)
                CN_CLOSED: if (!listenMode) setPend = FLG_SYN;
                CN_LISTEN: if (rxSyn) setPend = FLG_SYN | FLG_ACK;
                CN_SYNSENT: if (rxSynAck) setPend = FLG_ACK;
                CN_SYNRCVD, CN_OPEN: setPend = 8'h00;
            endcase
        end
    end

    // connection engine, active or passive open
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            conn_reg <= CN_CLOSED;
        end else if (!needConn) begin
            conn_reg <= CN_CLOSED;
        end else begin
            unique case (conn_reg)
                CN_CLOSED: conn_reg <= listenMode ? CN_LISTEN : CN_SYNSENT;
                CN_LISTEN: if (rxSyn) conn_reg <= CN_SYNRCVD;
                CN_SYNSENT: if (rxSynAck) conn_reg <= CN_OPEN;
                CN_SYNRCVD: if (rxAck) conn_reg <= CN_OPEN;
                CN_OPEN: conn_reg <= CN_OPEN;
            endcase
        end
    end

    // expected peer sequence and captured peer identity
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {ackExp_reg, peerMac, peerIp, peerPort} <= '0;
        end else if (needConn) begin
            if (conn_reg == CN_LISTEN && rxSyn) begin
                ackExp_reg <= rxSeq + 32'h1;
                peerMac <= rxPeerMac;
                peerIp <= rxPeerIp;
                peerPort <= rxPeerPort;
            end
            if (conn_reg == CN_SYNSENT && rxSynAck) ackExp_reg <= rxSeq + 32'h1;
        end
    end

    // pending control segments, a new request beats the clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pendFlags_reg <= 8'h00;
        end else begin
            pendFlags_reg <= (takePend ? 8'h00 : pendFlags_reg) | setPend;
        end
    end

    // frame sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= S_IDLE;
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    if (takePend) begin
                        state_reg <= S_HDR;
                    end else if (txGo && txAllowed) begin
                        state_reg <= S_PAY;
                    end
                end
                S_PAY: if (push && last) state_reg <= S_HDR;
                S_HDR: state_reg <= S_IDLE;
            endcase
        end
    end

    // per-frame kind and length
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {isCtl_reg, ctlFlags_reg, frameLen_reg} <= '0;
        end else if (state_reg == S_IDLE) begin
            if (takePend) begin
                isCtl_reg <= 1'b1;
                ctlFlags_reg <= pendFlags_reg;
                frameLen_reg <= 16'h0000;
            end else if (txGo) begin
                isCtl_reg <= 1'b0;
                frameLen_reg <= (payloadLen < {12'h000, tagLenC}) ? {12'h000, tagLenC} : payloadLen;
            end
        end
    end

    assign tagLenC = (tagLen < TAG_MIN) ? TAG_MIN : ((tagLen > TAG_MAX) ? TAG_MAX : tagLen);
    assign isTag = byteIdx_reg < {12'h000, tagLenC};
    assign last = byteIdx_reg == frameLen_reg - 16'h0001;
    assign push = (state_reg == S_PAY) && fifoReady;

    // payload byte: tag first, then pattern, then variable field overlay
    always_comb begin
        prbsNext = prbs8(prbs_reg, patSel);
        pos = 19'h00000;
        rel = 19'h00000;
        vIdx = 5'h00;
        if (isTag) begin
            rawByte = measTag[103 - 8 * byteIdx_reg[3:0] -: 8];
        end else begin
            case (patSel)
                PAT_5555: rawByte = PAT_ALT_BYTE;
                PAT_USER: rawByte = userPattern[31 - 8 * uPos_reg -: 8];
                default: rawByte = prbsNext[7:0];
            endcase
        end
        outByte = rawByte;
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < 8; k++) begin
                pos = {byteIdx_reg, 3'b000} + 19'(k);
                rel = pos - varOffset[f];
                if (pos >= varOffset[f] && rel < {13'h0000, varLen[f]}) begin
                    vIdx = 5'(varLen[f] - 6'd1 - rel[5:0]);
                    outByte[7 - k] = curVal[f][vIdx];
                end
            end
        end
    end

    // byte position and running data sum
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {byteIdx_reg, sum_reg} <= '0;
        end else if (state_reg == S_IDLE) begin
            {byteIdx_reg, sum_reg} <= '0;
        end else if (push) begin
            byteIdx_reg <= byteIdx_reg + 16'h0001;
            sum_reg <= sum_reg + (byteIdx_reg[0] ? {24'h0, outByte} : {16'h0, outByte, 8'h00});
        end
    end

    // pattern position, restarted or carried between frames
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {prbs_reg, uPos_reg} <= {PRBS_SEED, 2'b00};
        end else if (state_reg == S_IDLE && !takePend && txGo && txAllowed) begin
            if (!crossFrame) begin
                {prbs_reg, uPos_reg} <= {PRBS_SEED, 2'b00};
            end
        end else if (push && !isTag) begin
            prbs_reg <= prbsNext[38:8];
            uPos_reg <= uPos_reg + 2'b01;
        end
    end

    tsb_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) uFifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(state_reg == S_PAY),
        .inData({last, outByte}),
        .inReady(fifoReady),
        .outValid(payValid),
        .outData({payLast, payData}),
        .outReady(payReady)
    );

    // header field values for the segment being closed
    always_comb begin
        if (isCtl_reg) begin
            segFlags = ctlFlags_reg;
        end else if (needConn) begin
            segFlags = (cfgFlags & ENGINE_KEEP) | FLG_ACK | FLG_PSH;
        end else begin
            segFlags = cfgFlags;
        end
        if (!isCtl_reg && seqAutoInc) begin
            seqVal = dataSent_reg;
        end else begin
            seqVal = synSent_reg ? cfgSeq + 32'h1 : cfgSeq;
        end
        if ((segFlags & FLG_ACK) != 8'h00) begin
            ackVal = needConn ? ackExp_reg : cfgAck;
        end else begin
            ackVal = RST_WORD;
        end
        dport = listenMode ? peerPort : dstPort;
        segLen = (useTcp ? TCP_HDR_LEN : UDP_HDR_LEN) + frameLen_reg;
        hsum = sum_reg + {16'h0, pseudoSum} + {16'h0, srcPort} + {16'h0, dport}
            + {16'h0, segLen};
        if (useTcp) begin
            hsum = hsum + {16'h0, seqVal[31:16]} + {16'h0, seqVal[15:0]}
                + {16'h0, ackVal[31:16]} + {16'h0, ackVal[15:0]}
                + {16'h0, TCP_HDR_WORDS, TCP_RSVD, segFlags} + {16'h0, window}
                + {16'h0, ((segFlags & FLG_URG) != 8'h00) ? urgPtr : 16'h0000};
        end else begin
            hsum = hsum + {16'h0, segLen};
        end
        fold1 = {1'b0, hsum[15:0]} + {1'b0, hsum[31:16]};
        fold2 = fold1[15:0] + {15'h0000, fold1[16]};
        csumCalc = ~fold2;
    end

    // header outputs, loaded as a segment closes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {hdrValid, hdrIsCtl, seqField, ackField, offResField, flagsField} <= '0;
            {urgField, dstPortField, lenField, csumField} <= '0;
        end else begin
            hdrValid <= state_reg == S_HDR;
            if (state_reg == S_HDR) begin
                hdrIsCtl <= isCtl_reg;
                seqField <= seqVal;
                ackField <= ackVal;
                offResField <= {TCP_HDR_WORDS, TCP_RSVD};
                flagsField <= segFlags;
                urgField <= ((segFlags & FLG_URG) != 8'h00) ? urgPtr : 16'h0000;
                dstPortField <= dport;
                lenField <= segLen;
                if (useTcp) begin
                    csumField <= csumCalc;
                end else if (udpNullCsum) begin
                    csumField <= 16'h0000;
                end else begin
                    csumField <= (csumCalc == 16'h0000) ? 16'hFFFF : csumCalc;
                end
            end
        end
    end

    // sequence bookkeeping after each segment
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {synSent_reg, dataSent_reg} <= '0;
        end else if (state_reg == S_HDR) begin
            if ((segFlags & FLG_SYN) != 8'h00) synSent_reg <= 1'b1;
            if (!isCtl_reg) dataSent_reg <= dataSent_reg + {16'h0, frameLen_reg};
        end
    end

    // variable fields, stepped once per data frame
    for (genvar g = 0; g < 2; g++) begin : gVar
        logic armed_reg;
        logic [31:0] val_reg;
        logic [31:0] rnd_reg;
        logic [31:0] nextVal;
        assign curVal[g] = armed_reg ? val_reg : varStart[g];
        assign varValue[g] = curVal[g];
        always_comb begin
            case (varType[g])
                CHG_INC: begin
                    if ({1'b0, curVal[g]} + {1'b0, varStep[g]} > {1'b0, varEnd[g]}) begin
                        nextVal = varStart[g];
                    end else begin
                        nextVal = curVal[g] + varStep[g];
                    end
                end
                CHG_DEC: begin
                    if ({1'b0, curVal[g]} < {1'b0, varEnd[g]} + {1'b0, varStep[g]}) begin
                        nextVal = varStart[g];
                    end else begin
                        nextVal = curVal[g] - varStep[g];
                    end
                end
                default: nextVal = varStart[g] + (rnd_reg & (varEnd[g] - varStart[g]));
            endcase
        end
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                rnd_reg <= VAR_RND_SEED;
            end else begin
                rnd_reg <= {rnd_reg[30:0], rnd_reg[31] ^ rnd_reg[21] ^ rnd_reg[1] ^ rnd_reg[0]};
            end
        end
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                {armed_reg, val_reg} <= '0;
            end else if (state_reg == S_HDR && !isCtl_reg) begin
                armed_reg <= 1'b1;
                val_reg <= nextVal;
            end
        end
    end
endmodule // tsb_builder

// ---- test/tsb_builder_properties.sv ----
// concurrent checks on the builder's address, receive and header ports
`timescale 1ns/1ps
module tsb_builder_properties (
    input wire logic clk, sys_rst, gatewayEn, joined, rxValid, useTcp, udpNullCsum,
    input wire logic autoConnect, listenMode, groupOk, rxAccept, connOpen, txAllowed,
    input wire logic hdrValid, hdrIsCtl,
    input wire logic [31:0] gatewayIp, prefixMask, srcIp, dstIp, nextHopIp, rxDstIp,
    input wire logic [127:0] groupAddr, rxSrcAddr,
    input wire logic [7:0] offResField,
    input wire logic [15:0] csumField
);
    import tsb_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic offNet;
    logic grpHit;
    // off-net destination with gateway on
    assign offNet = gatewayEn && ((dstIp ^ srcIp) & prefixMask) != '0;
    assign grpHit = joined && groupOk;
    property p_gw; offNet |=> nextHopIp == $past(gatewayIp); endproperty
    a_gw: assert property (p_gw) else $error("next hop is not the gateway");
    property p_local; !offNet |=> nextHopIp == $past(dstIp); endproperty
    a_local: assert property (p_local) else $error("next hop is not dst");
    property p_grp; groupAddr[127:120] == MCAST_PREFIX |=> groupOk; endproperty
    a_grp: assert property (p_grp) else $error("group address refused");
    property p_nogrp; groupAddr[127:120] != MCAST_PREFIX |=> !groupOk; endproperty
    a_nogrp: assert property (p_nogrp) else $error("bad group accepted");
    property p_acc; rxValid && grpHit && rxSrcAddr == groupAddr |=> rxAccept; endproperty
    a_acc: assert property (p_acc) else $error("group packet dropped");
    property p_rej; rxValid && grpHit && rxSrcAddr != groupAddr |=> !rxAccept; endproperty
    a_rej: assert property (p_rej) else $error("own address used");
    property p_gate;
        txAllowed == (!(useTcp && (autoConnect || listenMode)) || connOpen);
    endproperty
    a_gate: assert property (p_gate) else $error("traffic gate wrong");
    property p_early; hdrValid && !hdrIsCtl |-> txAllowed; endproperty
    a_early: assert property (p_early) else $error("data before open");
    property p_off; hdrValid |-> offResField == {TCP_HDR_WORDS, TCP_RSVD}; endproperty
    a_off: assert property (p_off) else $error("offset field wrong");
    property p_null; hdrValid && !useTcp && udpNullCsum |-> csumField == '0; endproperty
    a_null: assert property (p_null) else $error("null checksum not zero");
    c_ctl: cover property (hdrValid && hdrIsCtl);
    c_acc: cover property (rxAccept);
    c_open: cover property ($rose(connOpen));
endmodule // tsb_builder_properties

// ---- test/tsb_peer.sv ----
// far-side peer: answers handshakes and sinks payload with optional stalls
`timescale 1ns/1ps
module tsb_peer (
    input wire logic clk, sys_rst, hdrValid, hdrIsCtl, stall, openReq,
    input wire logic [7:0] flagsField,
    output logic payReady, rxSyn, rxSynAck, rxAck
);
    import tsb_pkg::*;
    // open on request, answer SYN with SYN-ACK and SYN-ACK with ACK
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {rxSyn, rxSynAck, rxAck} <= '0;
        end else begin
            rxSyn <= openReq;
            rxSynAck <= hdrValid && hdrIsCtl && flagsField == FLG_SYN;
            rxAck <= hdrValid && hdrIsCtl && flagsField == (FLG_SYN | FLG_ACK);
        end
    end
    // sink holds off while stalled
    assign payReady = !stall;
endmodule // tsb_peer

// ---- test/tsb_builder_tb.sv ----
// self-checking bench for the test stream builder
`timescale 1ns/1ps
module tsb_builder_tb;
    import tsb_pkg::*;
    logic clk = 0, sys_rst = 1, gatewayEn, joined, rxValid, useTcp, udpNullCsum, seqAutoInc;
    logic autoConnect, listenMode, rxSyn, rxSynAck, rxAck, txGo, crossFrame, payReady, stall;
    logic groupOk, rxAccept, connOpen, txAllowed, busy, hdrValid, hdrIsCtl, payValid, payLast;
    logic openReq, sawHdr, same;
    logic [31:0] gatewayIp, prefixMask, srcIp, dstIp, nextHopIp, rxDstIp, cfgSeq, cfgAck;
    logic [31:0] rxSeq, rxPeerIp, peerIp, userPattern, seqField, ackField;
    logic [127:0] groupAddr, rxSrcAddr;
    logic [15:0] srcPort, dstPort, window, urgPtr, rxPeerPort, peerPort, pseudoSum, payloadLen;
    logic [15:0] urgField, dstPortField, lenField, csumField;
    logic [47:0] rxPeerMac, peerMac;
    logic [7:0] cfgFlags, offResField, flagsField, payData;
    logic [7:0] got[$], keep[$];
    logic [3:0] tagLen;
    logic [103:0] measTag;
    logic [1:0][18:0] varOffset;
    logic [1:0][5:0] varLen;
    logic [1:0][31:0] varStart, varEnd, varStep, varValue;
    logic [1:0][1:0] varType;
    tsb_pat_t patSel;
    int fail_count = 0, tests_run = 0, cyc = 0;
    // 40 MHz clock
    always #12.5 clk = !clk;
    tsb_builder dut (.*);
    tsb_peer peer (.*);
    // collect bytes and header strobes, timeout
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (payValid && payReady)
            got.push_back(payData);
        if (hdrValid)
            sawHdr <= 1'b1;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [127:0] a, e);
        tests_run++;
        if (a !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got %0h exp %0h", $time, a, e);
        end
    endtask
    // whole cycles, then the input skew
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge clk);
            #2;
        end
    endtask
    task automatic rst();
        sys_rst = 1;
        tk(3);
        sys_rst = 0;
        tk(1);
    endtask
    task automatic rx();
        tk(1);
        rxValid = 1;
        tk(1);
        rxValid = 0;
    endtask
    task automatic hdr();
        sawHdr = 0;
        for (int i = 0; i < 300 && !sawHdr; i++)
            tk(1);
        chk(sawHdr, 1);
    endtask
    // one frame, sink stalled st+1 cycles when st is nonzero
    task automatic frame(input int st);
        got = {};
        sawHdr = 0;
        stall = st > 0;
        txGo = 1;
        tk(1);
        txGo = 0;
        tk(st);
        if (st > 0)
            chk(busy, 1);
        stall = 0;
        for (int i = 0; i < 300 && !(sawHdr && !payValid); i++)
            tk(1);
    endtask
    initial begin
        {gatewayEn, gatewayIp, prefixMask, srcIp, dstIp, groupAddr, joined, rxValid, rxSrcAddr,
         rxDstIp, useTcp, udpNullCsum, window, cfgSeq, seqAutoInc, cfgAck, cfgFlags, urgPtr,
         autoConnect, listenMode, rxSeq, pseudoSum, txGo, crossFrame, measTag, stall,
         openReq} = '0;
        {srcPort, dstPort, rxPeerPort, rxPeerIp, rxPeerMac} = {16'h0400, 16'h0500, 16'h1F90,
         32'hC0A80009, 48'h0200000000AB};
        {varOffset, varLen, varType} = {19'h7FF00, 19'h7FF00, 6'h8, 6'h8, CHG_DEC, CHG_INC};
        {varStart, varEnd, varStep} = {32'h9, 32'h1, 32'h7, 32'h3, 32'h1, 32'h1};
        patSel = PAT_USER;
        {userPattern, tagLen, payloadLen} = {32'h5A5A5A5A, 4'h4, 16'h0014};
        measTag[103:72] = 32'hC1C2C3C4;
        rst();
        {srcIp, prefixMask, gatewayIp, gatewayEn} = {32'h0A000001, 32'hFFFFFF00, 32'h0A0000FE, 1'b1};
        dstIp = 32'h0B000005;
        tk(2);
        chk(nextHopIp, gatewayIp);
        dstIp = 32'h0A000007;
        tk(2);
        chk(nextHopIp, dstIp);
        groupAddr = {8'hFE, 120'h1};
        tk(2);
        chk(groupOk, 0);
        {groupAddr[127:120], joined, rxSrcAddr} = {8'hFF, 1'b1, 8'hFF, 120'h1};
        tk(1);
        rx();
        chk(rxAccept, 1);
        {rxSrcAddr[0], rxDstIp} = {1'b0, srcIp};
        rx();
        chk(rxAccept, 0);
        udpNullCsum = 1;
        for (int f = 0; f < 3; f++) begin
            frame(f == 0 ? 30 : 0);
            chk(got.size(), 20);
            chk({got[0], got[1], got[2], got[3], got[9]}, 40'hC1C2C3C45A);
            chk({lenField, csumField, dstPortField}, {UDP_HDR_LEN + 16'h14, 32'h0500});
            chk(varValue, {f == 2 ? 32'h9 : 32'h8 - f, f == 2 ? 32'h1 : 32'h2 + f});
        end
        patSel = PAT_PRBS9;
        for (int c = 0; c < 2; c++) begin
            crossFrame = c;
            frame(0);
            keep = got;
            frame(0);
            same = 1;
            for (int i = 4; i < 20; i++)
                same &= keep[i] === got[i];
            chk(same, !c);
        end
        {useTcp, autoConnect, cfgSeq, rxSeq} = {2'b11, 32'h100, 32'h500};
        rst();
        chk(txAllowed, 0);
        hdr();
        chk({flagsField, seqField}, {FLG_SYN, 32'h100});
        hdr();
        chk(ackField, 32'h501);
        tk(2);
        chk(connOpen, 1);
        frame(0);
        chk({seqField, flagsField & FLG_ACK}, {32'h101, FLG_ACK});
        {autoConnect, listenMode, seqAutoInc, cfgFlags, urgPtr} = {3'b011, FLG_URG, 16'h33};
        rst();
        chk(txAllowed, 0);
        openReq = 1;
        tk(1);
        openReq = 0;
        hdr();
        chk(flagsField, FLG_SYN | FLG_ACK);
        tk(3);
        chk({connOpen, peerPort, peerIp, peerMac}, {1'b1, rxPeerPort, rxPeerIp, rxPeerMac});
        for (int f = 0; f < 2; f++) begin
            frame(0);
            chk({seqField, dstPortField, urgField}, {32'h14 * f, 16'h1F90, 16'h33});
        end
        stop_test();
    end
endmodule // tsb_builder_tb
bind tsb_builder tsb_builder_properties chk_i (.*);
